// ---- src/pwm_consts.vh ----
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH

// Reference clock rate in hertz
`define PWM_CLK_HZ      33'd25000000
// Frequency setting limits in hertz
`define PWM_FREQ_MIN    16'd50
`define PWM_FREQ_MAX    16'd50000
// Duty value for full on-time, hundredths of a percent
`define PWM_DUTY_FULL   14'd10000
`define PWM_DUTY_HALF   33'd5000
// Number of channels and divider step count
`define PWM_NUM_CH      4
`define PWM_DIV_STEPS   6'd33
// Width of period and on-time counts in clock cycles
`define PWM_CNT_W       20

`endif

// ---- src/pwm_channel.v ----
`timescale 1ns/10ps
`include "pwm_consts.vh"

module pwm_channel #(
    parameter CNT_W = `PWM_CNT_W
) (
    input  wire             i_mclk,
    input  wire             i_rst_n,
    input  wire             i_load,
    input  wire [CNT_W-1:0] i_period,
    input  wire [CNT_W-1:0] i_on,
    output wire             o_pwm
);

    reg [CNT_W-1:0] period_r;
    reg [CNT_W-1:0] on_r;
    reg [CNT_W-1:0] new_period_r;
    reg [CNT_W-1:0] new_on_r;
    reg             pending_r;
    reg [CNT_W-1:0] cnt_r;
    reg             pwm_r;
    wire            last_w;
    wire            running_w;

    // =====================================================
    // Period counter
    // =====================================================
    assign running_w = (period_r != {CNT_W{1'b0}});
    assign last_w    = (cnt_r == period_r - {{(CNT_W-1){1'b0}}, 1'b1});
    assign o_pwm     = pwm_r;

    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            period_r     <= {CNT_W{1'b0}};
            on_r         <= {CNT_W{1'b0}};
            new_period_r <= {CNT_W{1'b0}};
            new_on_r     <= {CNT_W{1'b0}};
            pending_r    <= 1'b0;
            cnt_r        <= {CNT_W{1'b0}};
            pwm_r        <= 1'b0;
        end else begin
            if (i_load) begin
                new_period_r <= i_period;
                new_on_r     <= i_on;
            end
            // Settings swap only at a period boundary, or at once when idle
            if ((pending_r || i_load) && (!running_w || last_w)) begin
                period_r  <= i_load ? i_period : new_period_r;
                on_r      <= i_load ? i_on : new_on_r;
                pending_r <= 1'b0;
                cnt_r     <= {CNT_W{1'b0}};
            end else begin
                if (i_load) begin
                    pending_r <= 1'b1;
                end
                if (running_w) begin
                    cnt_r <= last_w ? {CNT_W{1'b0}}
                                    : cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end
            end
            // Fully on for the on-interval, fully off for the rest
            pwm_r <= running_w && (cnt_r < on_r);
        end
    end

endmodule

// ---- src/four_channel_pwm_outputs.v ----
// Notes on behaviour
// - Four independent channels, each with own frequency, duty and output.
// - Outputs five to eight: output five is channel three, eight is channel two.
// - Any frequency from 50 Hz to 50 kHz is accepted; outside values clamp.
// - Each period: fully on for on-interval, then fully off, constant timing.
// - Period is on plus off; duty is on-interval over period.
// - Duty value counts hundredths of a percent; 9500 means 95 percent.
// - Duty step 0.01 percent at 50 Hz, no coarser than 0.2 percent (one cycle of 500 at 50 kHz).
// - Period count is rounded to nearest cycle to keep frequency error small.
`timescale 1ns/10ps
`include "pwm_consts.vh"

module four_channel_pwm_outputs #(
    parameter CNT_W = `PWM_CNT_W
) (
    input  wire        i_mclk,
    input  wire        i_rst_n,
    input  wire        i_cmd_valid,
    input  wire [2:0]  i_cmd_chan,
    input  wire [13:0] i_cmd_duty,
    input  wire [15:0] i_cmd_freq,
    output wire        o_cmd_ready,
    output wire [3:0]  o_dout
);

    localparam [3:0] S_IDLE = 4'h1;
    localparam [3:0] S_PER  = 4'h2;
    localparam [3:0] S_ON   = 4'h4;
    localparam [3:0] S_LOAD = 4'h8;

    reg  [3:0]       state_r;
    reg              ready_r;
    reg  [1:0]       chan_r;
    reg  [13:0]      duty_r;
    reg  [CNT_W-1:0] period_r;
    reg  [32:0]      num_r;
    reg  [19:0]      den_r;
    reg  [33:0]      rem_r;
    reg  [32:0]      quo_r;
    reg  [5:0]       cnt_r;
    reg  [3:0]       load_r;
    wire [33:0]      rem_sh_w;
    wire             fit_w;
    wire [33:0]      rem_nxt;
    wire [32:0]      quo_nxt;
    wire [33:0]      prod_w;
    wire [3:0]       pwm_w;
    wire             chan_ok_w;
    wire [13:0]      duty_clamp_w;
    wire [15:0]      duty_wide_w;
    wire [15:0]      freq_clamp_w;

    // =====================================================
    // Helper functions
    // =====================================================
    // Limit a command field to its legal range
    function [15:0] clamp_range;
        input [15:0] val;
        input [15:0] lo;
        input [15:0] hi;
        begin
            if (val < lo) begin
                clamp_range = lo;
            end else if (val > hi) begin
                clamp_range = hi;
            end else begin
                clamp_range = val;
            end
        end
    endfunction

    // One-hot load strobe for a zero-based channel index
    function [3:0] chan_mask;
        input [1:0] idx;
        begin
            case (idx)
                2'h0: chan_mask = 4'h1;
                2'h1: chan_mask = 4'h2;
                2'h2: chan_mask = 4'h4;
                default: chan_mask = 4'h8;
            endcase
        end
    endfunction

    // =====================================================
    // Command clamping
    // =====================================================
    assign chan_ok_w    = (i_cmd_chan >= 3'h1) && (i_cmd_chan <= 3'h4);
    assign duty_wide_w  = clamp_range({2'b00, i_cmd_duty}, 16'h0000,
                                      {2'b00, `PWM_DUTY_FULL});
    assign duty_clamp_w = duty_wide_w[13:0];
    assign freq_clamp_w = clamp_range(i_cmd_freq, `PWM_FREQ_MIN,
                                      `PWM_FREQ_MAX);

    // =====================================================
    // Shared restoring divider step
    // =====================================================
    assign rem_sh_w = {rem_r[32:0], num_r[32]};
    assign fit_w    = (rem_sh_w >= {14'h0000, den_r});
    assign rem_nxt  = fit_w ? rem_sh_w - {14'h0000, den_r} : rem_sh_w;
    assign quo_nxt  = {quo_r[31:0], fit_w};
    // On-time in hundredths of a percent of a clock cycle
    assign prod_w   = period_r * duty_r;

    // =====================================================
    // Command sequencer
    // =====================================================
    // One command is worked at a time. The period count is found first,
    // then the on-time count from it, so both share one divider and the
    // on-time can never exceed the period. The channel only sees the pair
    // on a one-cycle load strobe, with both values already settled.
    // Commands that arrive while busy are dropped; the caller must wait
    // for ready. At the top frequency the period is only 500 clock cycles,
    // so the duty step there is limited by the reference clock.
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_r  <= S_IDLE;
            ready_r  <= 1'b0;
            chan_r   <= 2'h0;
            duty_r   <= 14'h0000;
            period_r <= {CNT_W{1'b0}};
            num_r    <= 33'h000000000;
            den_r    <= 20'h00000;
            rem_r    <= 34'h000000000;
            quo_r    <= 33'h000000000;
            cnt_r    <= 6'h00;
            load_r   <= 4'h0;
        end else begin
            load_r <= 4'h0;
            case (state_r)
                S_IDLE: begin
                    ready_r <= 1'b1;
                    if (ready_r && i_cmd_valid && chan_ok_w) begin
                        chan_r  <= i_cmd_chan[1:0] - 2'h1;
                        duty_r  <= duty_clamp_w;
                        // Rounded clock/frequency keeps frequency error low
                        num_r   <= `PWM_CLK_HZ + {18'h00000, freq_clamp_w[15:1]};
                        den_r   <= {4'h0, freq_clamp_w};
                        rem_r   <= 34'h000000000;
                        quo_r   <= 33'h000000000;
                        cnt_r   <= `PWM_DIV_STEPS;
                        ready_r <= 1'b0;
                        state_r <= S_PER;
                    end
                end
                S_PER, S_ON: begin
                    num_r <= {num_r[31:0], 1'b0};
                    rem_r <= rem_nxt;
                    quo_r <= quo_nxt;
                    cnt_r <= cnt_r - 6'h01;
                    if (cnt_r == 6'h01) begin
                        if (state_r == S_PER) begin
                            period_r <= quo_nxt[CNT_W-1:0];
                            state_r  <= S_LOAD;
                        end else begin
                            state_r  <= S_IDLE;
                            load_r   <= chan_mask(chan_r);
                        end
                    end
                end
                S_LOAD: begin
                    num_r   <= prod_w[32:0] + `PWM_DUTY_HALF;
                    den_r   <= {6'h00, `PWM_DUTY_FULL};
                    rem_r   <= 34'h000000000;
                    quo_r   <= 33'h000000000;
                    cnt_r   <= `PWM_DIV_STEPS;
                    state_r <= S_ON;
                end
                default: begin
                    state_r <= S_IDLE;
                end
            endcase
        end
    end

    assign o_cmd_ready = ready_r;

    // =====================================================
    // Channels
    // =====================================================
    genvar g;
    generate
        for (g = 0; g < `PWM_NUM_CH; g = g + 1) begin : g_ch
            pwm_channel #(
                .CNT_W    (CNT_W)
            ) u_ch (
                .i_mclk   (i_mclk),
                .i_rst_n  (i_rst_n),
                .i_load   (load_r[g]),
                .i_period (period_r),
                .i_on     (quo_r[CNT_W-1:0]),
                .o_pwm    (pwm_w[g])
            );
        end
    endgenerate

    // =====================================================
    // Output pin mapping
    // =====================================================
    // Output five carries channel three and output eight channel two
    assign o_dout[0] = pwm_w[2];
    assign o_dout[1] = pwm_w[3];
    assign o_dout[2] = pwm_w[0];
    assign o_dout[3] = pwm_w[1];

endmodule

// ---- verif/pwm_outputs_monitor.sv ----
`timescale 1ns/10ps
// ====
// Command port and output checks
module pwm_outputs_monitor #(
    parameter CNT_W = 20
) (
    input wire        i_mclk,
    input wire        i_rst_n,
    input wire        i_cmd_valid,
    input wire [2:0]  i_cmd_chan,
    input wire [13:0] i_cmd_duty,
    input wire [15:0] i_cmd_freq,
    input wire        o_cmd_ready,
    input wire [3:0]  o_dout
);
    wire take = i_cmd_valid && o_cmd_ready;
    wire good = i_cmd_chan != 3'h0 && i_cmd_chan < 3'h5;
    reg  seen_r;
    always @(posedge i_mclk or negedge i_rst_n) begin
        if (!i_rst_n)
            seen_r <= 1'b0;
        else if (take && good)
            seen_r <= 1'b1;
    end
    default clocking @(posedge i_mclk);
    endclocking
    default disable iff (!i_rst_n);
    a_take_ready_low: assert property (take && good |=> !o_cmd_ready)
        else $error("ready stayed high after accept");
    a_ready_back: assert property (take && good |-> ##[66:72] o_cmd_ready)
        else $error("ready did not return");
    a_bad_chan_kept: assert property (take && !good |=> o_cmd_ready)
        else $error("bad channel was accepted");
    a_busy_hold: assert property ($fell(o_cmd_ready) |-> !o_cmd_ready [*8])
        else $error("busy too short");
    a_reset_dark: assert property (disable iff (1'b0) !i_rst_n |-> o_dout == 4'h0)
        else $error("outputs active in reset");
    a_reset_busy: assert property (disable iff (1'b0) !i_rst_n |-> !o_cmd_ready)
        else $error("ready high in reset");
    a_unset_dark: assert property (!seen_r |-> o_dout == 4'h0)
        else $error("output active before any setting");
    a_ready_start: assert property ($rose(i_rst_n) |=> o_cmd_ready)
        else $error("ready late after reset");
endmodule

bind four_channel_pwm_outputs pwm_outputs_monitor #(.CNT_W(CNT_W)) i_pwm_outputs_monitor (
    .i_mclk(i_mclk), .i_rst_n(i_rst_n), .i_cmd_valid(i_cmd_valid), .i_cmd_chan(i_cmd_chan),
    .i_cmd_duty(i_cmd_duty), .i_cmd_freq(i_cmd_freq), .o_cmd_ready(o_cmd_ready),
    .o_dout(o_dout));

// ---- verif/pwm_load.sv ----
`timescale 1ns/10ps
// ====
// Load that times on-interval and period between rising edges
module pwm_load (
    input  wire i_mclk,
    input  wire i_line,
    output int  o_on,
    output int  o_per
);
    int   on_r = 0;
    int   per_r = 0;
    logic last_r = 1'b0;
    always @(posedge i_mclk) begin
        last_r <= i_line;
        per_r <= per_r + 1;
        on_r <= on_r + int'(i_line);
        if (i_line && !last_r) begin
            o_on <= on_r;
            o_per <= per_r;
            per_r <= 1;
            on_r <= 1;
        end
    end
endmodule

// ---- verif/four_channel_pwm_outputs_tb_top.sv ----
`timescale 1ns/10ps
// ====
// Bench
module four_channel_pwm_outputs_tb_top;
    logic        i_mclk = 1'b0;
    logic        i_rst_n = 1'b1;
    logic        i_cmd_valid = 1'b0;
    logic [2:0]  i_cmd_chan = 3'h0;
    logic [13:0] i_cmd_duty = 14'h0;
    logic [15:0] i_cmd_freq = 16'h0;
    wire         o_cmd_ready;
    wire  [3:0]  o_dout;
    int          on_c [4];
    int          per_c [4];
    int          err_total = 0;
    int          n_compared = 0;
    int          cyc = 0;
    four_channel_pwm_outputs i_four_channel_pwm_outputs (.i_mclk(i_mclk), .i_rst_n(i_rst_n),
        .i_cmd_valid(i_cmd_valid), .i_cmd_chan(i_cmd_chan), .i_cmd_duty(i_cmd_duty),
        .i_cmd_freq(i_cmd_freq), .o_cmd_ready(o_cmd_ready), .o_dout(o_dout));
    for (genvar g = 0; g < 4; g++) begin : g_load
        pwm_load i_pwm_load (.i_mclk(i_mclk), .i_line(o_dout[g]), .o_on(on_c[g]),
            .o_per(per_c[g]));
    end
    task automatic check(input bit ok, input string what);
        n_compared++;
        if (!ok) begin
            err_total++;
            $display("Error at %0t: %s", $time, what);
        end
    endtask
    task automatic send(input logic [2:0] ch, input logic [13:0] d, input logic [15:0] f);
        int n;
        n = 0;
        while (o_cmd_ready !== 1'b1 && n < 200) begin
            @(negedge i_mclk);
            n++;
        end
        check(n < 200, "ready never returned");
        @(posedge i_mclk);
        i_cmd_valid <= 1'b1;
        i_cmd_chan <= ch;
        i_cmd_duty <= d;
        i_cmd_freq <= f;
        @(posedge i_mclk);
        i_cmd_valid <= 1'b0;
    endtask
    task automatic t_channels;
        int b [4] = '{2, 3, 0, 1};
        int d [4] = '{500, 9500, 2500, 2};
        int f [4] = '{50000, 25000, 30000, 5000};
        int p [4] = '{500, 1000, 833, 5000};
        int o [4] = '{25, 950, 208, 1};
        send(3'h0, 14'h0, 16'h0);
        send(3'h5, 14'h0, 16'h0);
        for (int i = 0; i < 4; i++) begin
            send(3'(i + 1), 14'(d[i]), 16'(f[i]));
            @(posedge i_mclk);
            i_cmd_valid <= 1'b1;
            i_cmd_duty <= 14'h0;
            @(posedge i_mclk);
            i_cmd_valid <= 1'b0;
        end
        repeat (11000) @(posedge i_mclk);
        for (int i = 0; i < 4; i++) begin
            check(per_c[b[i]] === p[i], "wrong period");
            check(on_c[b[i]] === o[i], "wrong on-time");
        end
    endtask
    task automatic t_full_scale;
        int n;
        for (int k = 0; k < 2; k++) begin
            send(3'h2, k ? 14'h0 : 14'h2710, 16'h61a8);
            repeat (2100) @(posedge i_mclk);
            n = 0;
            repeat (1000) begin
                @(negedge i_mclk);
                n += int'(o_dout[3] !== (k == 0));
            end
            check(n == 0, "level not steady");
        end
    endtask
    task automatic complete_run;
        $display("Compared %0d, errors %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        forever #20 i_mclk = ~i_mclk;
    end
    always @(posedge i_mclk) begin
        cyc++;
        if (cyc == 40000) begin
            err_total++;
            complete_run();
        end
    end
    initial begin
        #5;
        i_rst_n <= 1'b0;
        repeat (20) @(posedge i_mclk);
        i_rst_n <= 1'b1;
        repeat (2) @(posedge i_mclk);
        t_channels();
        t_full_scale();
        complete_run();
    end
endmodule
